// ### verilog/zq_cal_ctrl.sv
// Controller end: APB-driven calibration sequencer with per-channel timers.
// Assumes APB on the same clock as the command bus.
`default_nettype none
module zq_cal_ctrl
  import zq_cal_pkg::*;
(
  input  wire logic                    CLOCK,
  input  wire logic                    RESET,
  zq_cal_if.ctrl                       BUS,
  input  wire logic                    PSEL,
  input  wire logic                    PENABLE,
  input  wire logic                    PWRITE,
  input  wire logic [7:0]              PADDR,
  input  wire logic [31:0]             PWDATA,
  output logic [31:0]                  PRDATA,
  output logic                         PREADY,
  output logic                         PSLVERR
);
  typedef struct packed {
    logic [NCH-1:0][CNT_W-1:0] run_cnt;
    logic [NCH-1:0][CNT_W-1:0] gap_cnt;
    logic [NCH-1:0][1:0]       req;
    logic [NCH-1:0]            need_cal;
    logic [NCH-1:0]            pwrdn;
    logic [NCH-1:0]            pucal;
    logic [NCH-1:0]            pu_wr;
    logic [NCH-1:0][2:0]       cmd;
    logic [NCH-1:0][7:0]       arg;
    logic [31:0]               rdata;
    logic                      slverr;
  } state_t;
  state_t s_r, s_nxt;

  localparam logic [1:0] REQ_NONE = 2'd0;

  always_comb
  begin
    logic wr;
    logic hit;
    wr = PSEL && PENABLE && PWRITE;
    hit = 1'b0;
    s_nxt = s_r;
    s_nxt.slverr = 1'b0;
    for (int c = 0; c < NCH; c++)
    begin
      s_nxt.cmd[c] = 3'(CMD_DESELECT);
      if (s_r.run_cnt[c] != '0)
        s_nxt.run_cnt[c] = s_r.run_cnt[c] - 1'b1;
      if (s_r.gap_cnt[c] != '0)
        s_nxt.gap_cnt[c] = s_r.gap_cnt[c] - 1'b1;
    end
    if (PSEL && PENABLE)
    begin
      if (PADDR == REG_CTRL)
        hit = 1'b1;
      else if (PADDR == REG_CFG)
        hit = 1'b1;
      else if (PADDR == REG_STATUS)
        hit = 1'b1;
      else if (PADDR == REG_CODE)
        hit = 1'b1;
      s_nxt.slverr = !hit;
      if (PADDR == REG_CTRL && wr)
        for (int c = 0; c < NCH; c++)
        begin
          if (PWDATA[CTRL_BEGIN+c])
            s_nxt.req[c] = 2'd1;
          else if (PWDATA[CTRL_APPLY+c])
            s_nxt.req[c] = 2'd2;
          else if (PWDATA[CTRL_DEFAULT+c])
            s_nxt.req[c] = 2'd3;
          else if (PWDATA[CTRL_PUCAL+c] != s_r.pucal[c])
          begin
            s_nxt.pucal[c] = PWDATA[CTRL_PUCAL+c];
            s_nxt.pu_wr[c] = 1'b1;
          end
          s_nxt.need_cal[c] = s_r.need_cal[c] | (PWDATA[CTRL_PUCAL+c] != s_r.pucal[c]);
        end
      else if (PADDR == REG_CFG && wr)
        s_nxt.pwrdn = PWDATA[NCH-1:0];
      if (PADDR == REG_STATUS)
        s_nxt.rdata = {24'h00_0000, s_r.need_cal, 2'b00,
                       s_r.run_cnt[1] != '0, s_r.run_cnt[0] != '0,
                       s_r.req[1] != REQ_NONE, s_r.req[0] != REQ_NONE};
      else if (PADDR == REG_CODE)
        s_nxt.rdata = {16'h0000, BUS.out_code[1], BUS.out_code[0]};
      else if (PADDR == REG_CFG)
        s_nxt.rdata = {30'h0000_0000, s_r.pwrdn};
      else
        s_nxt.rdata = RESET_WORD;
    end
    for (int c = 0; c < NCH; c++)
    begin
      if (s_r.gap_cnt[c] == '0 && !s_r.pwrdn[c])
      begin
        if (s_r.req[c] == 2'd1 && s_r.run_cnt[c] == '0)
        begin
          s_nxt.cmd[c] = 3'(CMD_BEGIN);
          s_nxt.run_cnt[c] = CNT_W'(RUN_CYC);
          s_nxt.need_cal[c] = 1'b0;
          s_nxt.req[c] = REQ_NONE;
        end
        else if (s_r.req[c] == 2'd2 && s_r.run_cnt[c] == '0 && !BUS.dq_busy[c])
        begin
          s_nxt.cmd[c] = 3'(CMD_APPLY);
          s_nxt.gap_cnt[c] = CNT_W'(APPLY_CYC);
          s_nxt.req[c] = REQ_NONE;
        end
        else if (s_r.req[c] == 2'd3)
        begin
          s_nxt.cmd[c] = 3'(CMD_DEFAULT);
          s_nxt.arg[c] = 8'h01;
          s_nxt.gap_cnt[c] = CNT_W'(DEFAULT_CYC);
          s_nxt.req[c] = REQ_NONE;
        end
        else if (s_r.pu_wr[c] && s_r.run_cnt[c] == '0)
        begin
          // Field write held back until the run timer expires
          s_nxt.cmd[c] = 3'(CMD_PUCAL_WR);
          s_nxt.arg[c] = {7'h00, s_r.pucal[c]};
          s_nxt.pu_wr[c] = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      BUS.cmd[c] = cmd_t'(s_r.cmd[c]);
      BUS.arg[c] = s_r.arg[c];
      BUS.pwrdn[c] = s_r.pwrdn[c];
    end
  end
  assign PRDATA = s_r.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = s_r.slverr & 1'b0;
endmodule
`default_nettype wire

// ### verilog/zq_cal_pkg.sv
// Constants and types shared by the calibration sequencer ends.
// Assumes one 20 MHz clock and synchronous active-high reset.
`default_nettype none
package zq_cal_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int NCH = 2;
  localparam int CODE_W = 8;
  // Calibration run and settle times
  localparam int RUN_TIME_NS = 1000;
  localparam int APPLY_TIME_NS = 30;
  localparam int APPLY_MIN_NCK = 8;
  localparam int DEFAULT_TIME_NS = 50;
  localparam int DEFAULT_MIN_NCK = 3;
  localparam int RUN_CYC = (RUN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APPLY_CYC_NS = (APPLY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int APPLY_CYC = (APPLY_CYC_NS > APPLY_MIN_NCK) ? APPLY_CYC_NS : APPLY_MIN_NCK;
  localparam int DEFAULT_CYC_NS = (DEFAULT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEFAULT_CYC =
    (DEFAULT_CYC_NS > DEFAULT_MIN_NCK) ? DEFAULT_CYC_NS : DEFAULT_MIN_NCK;
  localparam int CNT_W = 6;
  // Device internal calibration engine time in cycles
  localparam logic [CNT_W-1:0] ENGINE_CYC = CNT_W'(RUN_CYC - 2);
  localparam logic [CODE_W-1:0] CODE_DEFAULT = 8'h80;
  localparam logic [CODE_W-1:0] CODE_RESET = 8'h00;
  // Command encoding on the per-channel command bus
  typedef enum logic [2:0] {
    CMD_DESELECT,
    CMD_BEGIN,
    CMD_APPLY,
    CMD_DEFAULT,
    CMD_PUCAL_WR,
    CMD_TERM_WR,
    CMD_OTHER
  } cmd_t;
  // APB register offsets of the controller
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CFG = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_CODE = 8'h0C;
  // REG_CTRL write bits
  localparam int CTRL_BEGIN = 0;
  localparam int CTRL_APPLY = 2;
  localparam int CTRL_DEFAULT = 4;
  localparam int CTRL_TERM = 6;
  localparam int CTRL_PUCAL = 8;
  localparam int CTRL_OTHER = 10;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ### verilog/zq_cal_if.sv
// Command bus between controller and two-channel memory calibration logic.
// Assumes both ends share the same clock.
`default_nettype none
interface zq_cal_if;
  zq_cal_pkg::cmd_t                    cmd [zq_cal_pkg::NCH];
  logic [7:0]                          arg [zq_cal_pkg::NCH];
  logic                                pwrdn [zq_cal_pkg::NCH];
  logic                                dq_busy [zq_cal_pkg::NCH];
  logic [zq_cal_pkg::CODE_W-1:0]       out_code [zq_cal_pkg::NCH];
  modport ctrl (output cmd, output arg, output pwrdn, input dq_busy, input out_code);
  modport mem (input cmd, input arg, input pwrdn, output dq_busy, output out_code);
endinterface
`default_nettype wire

// ### verilog/zq_cal_mem.sv
// Memory end: shared calibration engine and per-channel applied codes.
// Assumes the controller keeps command spacing; clock shared with it.
`default_nettype none
module zq_cal_mem
  import zq_cal_pkg::*;
(
  input  wire logic                    CLOCK,
  input  wire logic                    RESET,
  zq_cal_if.mem                        BUS,
  input  wire logic [CODE_W-1:0]       PROCESS_CODE,
  output logic                         CAL_RUNNING,
  output logic [NCH-1:0]               APPLY_PENDING
);
  typedef struct packed {
    logic                  running;
    logic [CNT_W-1:0]      eng_cnt;
    logic [CODE_W-1:0]     latest;
    logic [CODE_W-1:0]     done_code;
    logic [NCH-1:0]        pend;
    logic [NCH-1:0][CNT_W-1:0] lat_cnt;
    logic [NCH-1:0][CODE_W-1:0] stage;
    logic [NCH-1:0][CODE_W-1:0] applied;
  } state_t;
  state_t s_r, s_nxt;

  always_comb
  begin
    logic begin_any;
    begin_any = 1'b0;
    s_nxt = s_r;
    for (int c = 0; c < NCH; c++)
    begin
      if (BUS.cmd[c] == CMD_BEGIN && !BUS.pwrdn[c])
        begin_any = 1'b1;
    end
    if (s_r.running)
    begin
      if (s_r.eng_cnt == '0)
      begin
        s_nxt.running = 1'b0;
        s_nxt.done_code = s_r.latest;
      end
      else
        s_nxt.eng_cnt = s_r.eng_cnt - 1'b1;
    end
    else if (begin_any)
    begin
      s_nxt.running = 1'b1;
      s_nxt.eng_cnt = ENGINE_CYC;
      s_nxt.latest = PROCESS_CODE;
    end
    for (int c = 0; c < NCH; c++)
    begin
      if (s_r.pend[c])
      begin
        if (s_r.lat_cnt[c] == '0)
        begin
          s_nxt.pend[c] = 1'b0;
          s_nxt.applied[c] = s_r.stage[c];
        end
        else
          s_nxt.lat_cnt[c] = s_r.lat_cnt[c] - 1'b1;
      end
      if (BUS.cmd[c] == CMD_APPLY && !BUS.pwrdn[c])
      begin
        s_nxt.pend[c] = 1'b1;
        s_nxt.lat_cnt[c] = CNT_W'(APPLY_CYC - 2);
        s_nxt.stage[c] = s_r.done_code;
      end
      else if (BUS.cmd[c] == CMD_DEFAULT && BUS.arg[c][0])
      begin
        s_nxt.pend[c] = 1'b0;
        s_nxt.applied[c] = CODE_DEFAULT;
      end
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      s_r <= '0;
      s_r.done_code <= CODE_DEFAULT;
      s_r.latest <= CODE_DEFAULT;
      for (int c = 0; c < NCH; c++)
      begin
        s_r.applied[c] <= CODE_DEFAULT;
        s_r.stage[c] <= CODE_DEFAULT;
      end
    end
    else
      s_r <= s_nxt;
  end

  always_comb
  begin
    for (int c = 0; c < NCH; c++)
    begin
      BUS.out_code[c] = s_r.applied[c];
      BUS.dq_busy[c] = 1'b0;
    end
  end
  assign CAL_RUNNING = s_r.running;
  assign APPLY_PENDING = s_r.pend;
endmodule
`default_nettype wire

// ### verification/zq_cal_monitor.sv
// Checker of the command bus between controller and memory ends.
// Assumes one clock and synchronous active-high reset.
`default_nettype none
module zq_cal_monitor (
  input wire logic                          CLOCK,
  input wire logic                          RESET,
  input wire zq_cal_pkg::cmd_t              cmd [zq_cal_pkg::NCH],
  input wire logic [7:0]                    arg [zq_cal_pkg::NCH],
  input wire logic                          pwrdn [zq_cal_pkg::NCH],
  input wire logic                          dq_busy [zq_cal_pkg::NCH],
  input wire logic [zq_cal_pkg::CODE_W-1:0] out_code [zq_cal_pkg::NCH]
);
  import zq_cal_pkg::*;
  default clocking mon_clk @(posedge CLOCK);
  endclocking
  default disable iff (RESET);
  // Cycles since a command, saturating
  function automatic int age(input int old, input logic hit);
    return hit ? 1 : (old < 63) ? old + 1 : 63;
  endfunction
  for (genvar c = 0; c < NCH; c++)
  begin : g_ch
    int beg_age;
    int app_age;
    int dfl_age;
    always_ff @(posedge CLOCK)
    begin
      beg_age <= RESET ? 63 : age(beg_age, cmd[c] == CMD_BEGIN);
      app_age <= RESET ? 63 : age(app_age, cmd[c] == CMD_APPLY);
      dfl_age <= RESET ? 63 : age(dfl_age, cmd[c] == CMD_DEFAULT);
    end
    chk_begin_awake: assert property (cmd[c] == CMD_BEGIN |-> !pwrdn[c])
      else $error("begin sent in power-down");
    chk_apply_ready: assert property (cmd[c] == CMD_APPLY
      |-> !pwrdn[c] && !dq_busy[c] && beg_age >= RUN_CYC) else $error("early apply");
    chk_apply_quiet: assert property (cmd[c] == CMD_APPLY
      |=> (cmd[c] == CMD_DESELECT) [*7]) else $error("command inside apply gap");
    chk_default_quiet: assert property (cmd[c] == CMD_DEFAULT
      |=> (cmd[c] == CMD_DESELECT) [*2]) else $error("command inside default gap");
    chk_field_hold: assert property (cmd[c] inside {CMD_PUCAL_WR, CMD_TERM_WR}
      |-> beg_age >= RUN_CYC) else $error("field written during run");
    chk_begin_spacing: assert property (cmd[c] == CMD_BEGIN
      |-> beg_age >= RUN_CYC) else $error("begin inside own run timer");
    chk_code_hold: assert property ($changed(out_code[c])
      |-> app_age inside {[APPLY_CYC:APPLY_CYC + 1]} || dfl_age <= DEFAULT_CYC + 1)
      else $error("driver code changed without cause");
    chk_default_code: assert property (cmd[c] == CMD_DEFAULT
      |-> ##[1:4] out_code[c] == CODE_DEFAULT) else $error("default code not restored");
  end
endmodule
`default_nettype wire

// ### verification/zq_impedance_calibration_test.sv
// Bench joining controller and memory ends over the command bus.
// Assumes the shared package and a 20 MHz clock.
`default_nettype none
module zq_impedance_calibration_test;
  timeunit 1ns;
  timeprecision 1ns;
  import zq_cal_pkg::*;
  logic              clock, reset, psel, penable, pwrite, pready, pslverr, rd_flag;
  logic [7:0]        paddr, code_in, r1;
  logic [31:0]       pwdata, prdata;
  logic [CODE_W-1:0] seen [NCH];
  logic [31:0]       rd_q [$];
  logic [31:0]       code_q [NCH][$];
  int                err_total = 0, num_checks = 0, cycles = 0;
  zq_cal_if bus ();
  zq_cal_ctrl zq_cal_ctrl_inst (.CLOCK(clock), .RESET(reset), .BUS(bus), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr));
  zq_cal_mem zq_cal_mem_inst (.CLOCK(clock), .RESET(reset), .BUS(bus),
    .PROCESS_CODE(code_in), .CAL_RUNNING(), .APPLY_PENDING());
  zq_cal_monitor zq_cal_monitor_inst (.CLOCK(clock), .RESET(reset), .cmd(bus.cmd),
    .arg(bus.arg), .pwrdn(bus.pwrdn), .dq_busy(bus.dq_busy), .out_code(bus.out_code));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out();
    for (int c = 0; c < NCH; c++)
      check("unconsumed code notes", RESET_WORD, 32'(code_q[c].size()));
    check("unconsumed read notes", RESET_WORD, 32'(rd_q.size()));
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // APB transfer; a read notes its expected data
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
      @(posedge clock);
    check("slave error", RESET_WORD, 32'(pslverr));
    psel <= 1'b0;
    penable <= 1'b0;
    if (!wr)
    begin
      rd_q.push_back(d);
      rd_flag <= 1'b1;
      @(posedge clock);
      rd_flag <= 1'b0;
    end
  endtask
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      err_total++;
      close_out();
    end
  end
  // Compares read data and every driver code change with the oldest note
  always @(posedge clock)
  begin
    if (rd_flag)
      check("read data", rd_q.pop_front(), prdata);
    for (int c = 0; c < NCH; c++)
    begin
      if (!reset && bus.out_code[c] !== seen[c])
        check("driver code", code_q[c].size() > 0 ? code_q[c].pop_front() : 32'(seen[c]),
          32'(bus.out_code[c]));
      seen[c] = bus.out_code[c];
    end
  end
  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = RESET_WORD;
    code_in = 8'h00;
    rd_flag = 1'b0;
    void'($urandom(32'he2ad));
    r1 = 8'($urandom()) & 8'h7F;
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    code_in <= r1;
    xfer(1'b0, REG_STATUS, RESET_WORD);
    xfer(1'b1, 8'h3C, 32'hFFFF_FFFF);
    xfer(1'b0, REG_CFG, RESET_WORD);
    xfer(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (3) @(posedge clock);
    code_in <= ~r1;
    xfer(1'b1, REG_CTRL, 32'h0000_0002);
    code_q[0].push_back(32'(r1));
    code_q[1].push_back(32'(r1));
    repeat (30) @(posedge clock);
    xfer(1'b1, REG_CTRL, 32'h0000_000C);
    repeat (12) @(posedge clock);
    code_q[1].push_back(32'(CODE_DEFAULT));
    xfer(1'b1, REG_CTRL, 32'h0000_0020);
    repeat (6) @(posedge clock);
    xfer(1'b1, REG_CTRL, 32'h0000_0300);
    repeat (4) @(posedge clock);
    xfer(1'b0, REG_STATUS, 32'h0000_00C0);
    xfer(1'b1, REG_CFG, 32'h0000_0001);
    xfer(1'b1, REG_CTRL, 32'h0000_0001);
    repeat (4) @(posedge clock);
    xfer(1'b0, REG_STATUS, 32'h0000_00C1);
    code_in <= r1 ^ 8'h41;
    xfer(1'b1, REG_CFG, RESET_WORD);
    code_q[0].push_back(32'(r1 ^ 8'h41));
    code_q[1].push_back(32'(r1 ^ 8'h41));
    repeat (30) @(posedge clock);
    xfer(1'b1, REG_CTRL, 32'h0000_000C);
    repeat (12) @(posedge clock);
    close_out();
  end
endmodule
`default_nettype wire
